/* File: rtl/fsr_pkg.sv */
/*
 Package for the flash status host controller: flash commands, status bit
 positions, host register map, interrupt bits and bus timing counts.
 Assumes a 20 MHz system clock and an asynchronous NOR flash outside.
*/
package fsr_pkg;
   // Flash commands
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_WORD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_BUFFER_SETUP = 8'hE8;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_RESUME = 8'hD0;
   // Status bit positions
   localparam int ST_READY = 7;
   localparam int ST_ERASE_ERR = 5;
   localparam int ST_PROG_ERR = 4;
   localparam int ST_VOLT = 3;
   localparam int ST_SUSP = 2;
   localparam int ST_LOCK = 1;
   localparam int XS_BUF_AVAIL = 7;
   // Masks applied when polling (reserved bits dropped)
   localparam logic [7:0] STATUS_POLL_MASK = 8'hFE;
   localparam logic [7:0] XSTATUS_POLL_MASK = 8'h80;
   // Host register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [3:0] REG_STAT = 4'hC;
   // Internal map beyond 16 bytes uses bit 4
   localparam logic [4:0] REG_IRQ_STAT = 5'h10;
   localparam logic [4:0] REG_IRQ_MASK = 5'h14;
   // Control operations (CTRL[3:0] written with bit 31 = go)
   localparam logic [3:0] OP_WRITE_CMD = 4'h0;
   localparam logic [3:0] OP_READ = 4'h1;
   localparam logic [3:0] OP_POLL_STATUS = 4'h2;
   localparam logic [3:0] OP_POLL_BUFFER = 4'h3;
   localparam logic [3:0] OP_CHECK_LOCK = 4'h4;
   localparam int CTRL_GO = 31;
   // Interrupt bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERROR = 1;
   localparam int IRQ_LOCKED = 2;
   localparam int IRQ_SEQ_ERR = 3;
   localparam int IRQ_W = 4;
   // Flash bus timing
   localparam int CLK_MHZ = 20;
   localparam int T_ACCESS_NS = 150;
   localparam int T_WRITE_NS = 100;
   localparam int ACC_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int WR_CYC = (T_WRITE_NS * CLK_MHZ + 999) / 1000;
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [23:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
   } fsr_pins_s;
endpackage

/* File: rtl/fsr_host.sv */
/*
 Host controller for the flash status reporting. Software drives it over
 Avalon-MM; it drives the flash pins, single-word cycles only.
 Assumes the flash data bus returns to clk_sys through dq_in.
*/
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Lock state read via identifier codes
// - Mask reserved lowest status bit
// - Mask extended reserved seven bits
// - Query read by single word only
module fsr_host (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   // Flash pins
   output fsr_pkg::fsr_pins_s flash_pins,
   input wire logic [15:0] dq_in
);
   typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_DONE} fsr_state_e;
   fsr_state_e state_reg;
   fsr_pkg::fsr_pins_s pins_reg;
   logic [15:0] dq_s1_reg, dq_s2_reg;
   logic [3:0] op_reg;
   logic [7:0] cmd_reg;
   logic [23:0] addr_reg;
   logic [15:0] data_reg;
   logic [15:0] rdata_reg;
   logic busy_reg;
   logic [7:0] cnt_reg;
   logic [fsr_pkg::IRQ_W-1:0] ista_reg, imask_reg;
   logic [31:0] rd_reg;
   logic wait_reg;

   wire logic is_rd = (op_reg != fsr_pkg::OP_WRITE_CMD);
   wire logic [7:0] step_cyc = is_rd ? 8'(fsr_pkg::ACC_CYC)
                                     : 8'(fsr_pkg::WR_CYC);
   wire logic [7:0] sampled = dq_s2_reg[7:0];
   wire logic ready_bit = sampled[fsr_pkg::ST_READY];
   wire logic [7:0] st_masked = sampled & fsr_pkg::STATUS_POLL_MASK;
   wire logic [7:0] held = rdata_reg[7:0];
   wire logic [7:0] held_st = held[fsr_pkg::ST_READY] ?
                              held & fsr_pkg::STATUS_POLL_MASK :
                              held & 8'h80;
   wire logic [7:0] xs_masked = held & fsr_pkg::XSTATUS_POLL_MASK;
   wire logic [7:0] st_valid = ready_bit ? st_masked : 8'h80 & st_masked;
   wire logic poll_op = (op_reg == fsr_pkg::OP_POLL_STATUS) ||
                        (op_reg == fsr_pkg::OP_CHECK_LOCK);
   wire logic finish = (state_reg == S_DONE);
   wire logic cyc_done = (state_reg == S_HOLD) && (cnt_reg == 8'h00);
   wire logic poll_again = cyc_done && poll_op && !ready_bit;
   wire logic op_end = cyc_done && !poll_again;
   wire logic seq_err = st_valid[fsr_pkg::ST_ERASE_ERR] &&
                        st_valid[fsr_pkg::ST_PROG_ERR];
   wire logic lock_err = st_valid[fsr_pkg::ST_LOCK] &&
                         st_valid[fsr_pkg::ST_PROG_ERR];
   wire logic any_err = st_valid[fsr_pkg::ST_VOLT] ||
                        st_valid[fsr_pkg::ST_PROG_ERR] ||
                        st_valid[fsr_pkg::ST_ERASE_ERR];
   wire logic [fsr_pkg::IRQ_W-1:0] ev;
   assign ev[fsr_pkg::IRQ_DONE] = op_end;
   assign ev[fsr_pkg::IRQ_ERROR] = op_end && poll_op && any_err;
   assign ev[fsr_pkg::IRQ_LOCKED] = op_end && poll_op && lock_err;
   assign ev[fsr_pkg::IRQ_SEQ_ERR] = op_end && poll_op && seq_err;
   wire logic req = avs_read || avs_write;
   // Commit only at the edge where waitrequest is seen low
   wire logic acc = req && !wait_reg;
   wire logic wr_ctrl = acc && avs_write && avs_address[4] == 1'b0 &&
                        avs_address[3:0] == fsr_pkg::REG_CTRL &&
                        avs_writedata[fsr_pkg::CTRL_GO] && !busy_reg;
   wire logic rd_ista = acc && avs_read &&
                        avs_address == fsr_pkg::REG_IRQ_STAT;
   wire logic [fsr_pkg::IRQ_W-1:0] ista_clr =
      rd_ista ? rd_reg[fsr_pkg::IRQ_W-1:0] : '0;
   wire logic [31:0] rd_mux =
      avs_address == {1'b0, fsr_pkg::REG_CTRL} ?
         {busy_reg, 19'h0, cmd_reg, op_reg} :
      avs_address == {1'b0, fsr_pkg::REG_ADDR} ? {8'h00, addr_reg} :
      avs_address == {1'b0, fsr_pkg::REG_DATA} ? {16'h0000, rdata_reg} :
      avs_address == {1'b0, fsr_pkg::REG_STAT} ?
         {16'h0000, (op_reg == fsr_pkg::OP_POLL_BUFFER) ? xs_masked
                                                        : held_st,
          rdata_reg[7:0]} :
      avs_address == fsr_pkg::REG_IRQ_STAT ? {28'h0, ista_reg} :
      avs_address == fsr_pkg::REG_IRQ_MASK ? {28'h0, imask_reg} : 32'h0;
   assign flash_pins = pins_reg;

   always_ff @(posedge clk_sys) begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
   end
   // One wait cycle per access; answer on the second edge
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         wait_reg <= 1'b1;
         rd_reg <= 32'h0;
      end else begin
         wait_reg <= !(req && wait_reg);
         // Read data captured early so it stands at the commit edge
         if (req && wait_reg) rd_reg <= rd_mux;
      end
   end
   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rd_reg;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ista_reg <= '0;
         imask_reg <= '0;
         irq <= 1'b0;
      end else begin
         // Only the bits returned are cleared; new events still win
         ista_reg <= (ista_reg & ~ista_clr) | ev;
         if (acc && avs_write && avs_address == fsr_pkg::REG_IRQ_MASK)
            imask_reg <= avs_writedata[fsr_pkg::IRQ_W-1:0];
         irq <= |(ista_reg & imask_reg);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         addr_reg <= '0;
         data_reg <= '0;
      end else if (acc && avs_write && !busy_reg) begin
         if (avs_address == {1'b0, fsr_pkg::REG_ADDR})
            addr_reg <= avs_writedata[23:0];
         if (avs_address == {1'b0, fsr_pkg::REG_DATA})
            data_reg <= avs_writedata[15:0];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_reg <= S_IDLE;
         busy_reg <= 1'b0;
         op_reg <= fsr_pkg::OP_WRITE_CMD;
         cmd_reg <= fsr_pkg::CMD_READ_ARRAY;
         cnt_reg <= 8'h00;
         rdata_reg <= '0;
         pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                       addr: '0, dq_out: '0, dq_oe: 1'b0};
      end else begin
         unique case (state_reg)
            S_IDLE: if (wr_ctrl) begin
               op_reg <= avs_writedata[3:0];
               cmd_reg <= avs_writedata[11:4];
               busy_reg <= 1'b1;
               state_reg <= S_SETUP;
            end
            S_SETUP: begin
               pins_reg.addr <= addr_reg;
               pins_reg.ce_n <= 1'b0;
               pins_reg.dq_oe <= !is_rd;
               pins_reg.dq_out <= (cmd_reg == fsr_pkg::CMD_WORD_PROGRAM &&
                                   op_reg == fsr_pkg::OP_WRITE_CMD) ?
                                  data_reg : {8'h00, cmd_reg};
               cnt_reg <= step_cyc;
               state_reg <= S_STROBE;
            end
            S_STROBE: begin
               pins_reg.oe_n <= !is_rd;
               pins_reg.we_n <= is_rd;
               state_reg <= S_HOLD;
            end
            S_HOLD: if (cnt_reg != 8'h00) begin
               cnt_reg <= cnt_reg - 8'h01;
            end else begin
               rdata_reg <= dq_s2_reg;
               pins_reg.oe_n <= 1'b1;
               pins_reg.we_n <= 1'b1;
               pins_reg.dq_oe <= 1'b0;
               pins_reg.ce_n <= 1'b1;
               state_reg <= poll_again ? S_SETUP : S_DONE;
            end
            S_DONE: begin
               busy_reg <= 1'b0;
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // Bus answer follows a seen request by one cycle
   sequence s_bus_req;
      req && wait_reg;
   endsequence
   sequence s_bus_ans;
      !wait_reg ##1 wait_reg;
   endsequence
   property p_bus_answer;
      @(posedge clk_sys) disable iff (!nrst) s_bus_req |=> s_bus_ans;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer not one cycle after request");
   property p_single_word;
      @(posedge clk_sys) disable iff (!nrst)
         !pins_reg.ce_n && !$past(pins_reg.ce_n) |-> $stable(pins_reg.addr);
   endproperty
   a_single_word: assert property (p_single_word)
      else $error("flash address moved inside one cycle");
   sequence s_lock_seen;
      op_end && poll_op && lock_err;
   endsequence
   property p_lock_flags;
      @(posedge clk_sys) disable iff (!nrst)
         s_lock_seen |=> ista_reg[fsr_pkg::IRQ_LOCKED] &&
                         ista_reg[fsr_pkg::IRQ_ERROR];
   endproperty
   a_lock_flags: assert property (p_lock_flags)
      else $error("lock abort not flagged with error");
   property p_sticky_error;
      @(posedge clk_sys) disable iff (!nrst)
         ista_reg[fsr_pkg::IRQ_ERROR] && !rd_ista |=>
            ista_reg[fsr_pkg::IRQ_ERROR];
   endproperty
   a_sticky_error: assert property (p_sticky_error)
      else $error("error flag dropped without a read");
   property p_done_frees;
      @(posedge clk_sys) disable iff (!nrst)
         finish |=> state_reg == S_IDLE && !busy_reg;
   endproperty
   a_done_frees: assert property (p_done_frees)
      else $error("controller not idle after finishing");
endmodule
`default_nettype wire

/* File: sim/fsr_flash_model.sv */
/*
 Flash device model: status, extended status, lock code and query reads.
 Assumes host pins with single-word cycles; ready at once, never busy.
*/
`timescale 1ns/10ps
`default_nettype none
module fsr_flash_model (
   // Host pins
   input wire fsr_pkg::fsr_pins_s pins,
   // Test controls
   input wire logic locked,
   input wire logic vpen_low,
   input wire logic buf_free,
   // Data back to host
   output logic [15:0] dq
);
   logic [7:0] sr = 8'h80;
   logic [7:0] mode = 8'hFF;
   logic arm = 1'b0;
   logic [15:0] rd;
   logic [15:0] last = 16'h0000;
   always @(posedge pins.we_n) begin
      if (arm) begin
         arm = 1'b0;
         mode = 8'h70;
         if (locked) sr = sr | 8'h12;
         else if (vpen_low) sr = sr | 8'h18;
      end else begin
         mode = pins.dq_out[7:0];
         if (mode == 8'h40) arm = 1'b1;
         if (mode == 8'h50) sr = 8'h80;
         if (mode == 8'hB0) sr[2] = 1'b1;
         if (mode == 8'hD0) sr[2] = 1'b0;
         // Clear status leaves the status read mode in place
         if (mode == 8'hB0 || mode == 8'hD0 || mode == 8'h50) mode = 8'h70;
      end
   end
   always_comb begin
      case (mode)
         8'h70: rd = {8'h00, sr | 8'h01};
         8'hE8: rd = {8'h00, buf_free, 7'h55};
         8'h90: rd = {15'h0000, locked};
         8'h98: rd = 16'h0051;
         default: rd = pins.addr[15:0];
      endcase
   end
   // Released bus shows the inverse of the last value, never a hold
   always @(pins or rd) begin
      if (!pins.ce_n && !pins.oe_n) last = rd;
   end
   assign dq = (!pins.ce_n && !pins.oe_n) ? rd : ~last;
endmodule
`default_nettype wire

/* File: sim/tb.sv */
/*
 Testbench for the flash status host controller.
 Assumes result in the data register and a done bit in interrupt status.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   wire logic [31:0] avs_readdata;
   wire logic avs_waitrequest;
   wire logic irq;
   fsr_pkg::fsr_pins_s pins;
   wire logic [15:0] dq;
   logic locked = 1'b0;
   logic vpen_low = 1'b0;
   logic buf_free = 1'b0;
   int err_total = 0;
   int cmp_count = 0;
   int exp_sr;
   logic [31:0] rv;
   logic [31:0] seed = 32'h00005CD7;
   always #25 clk_sys = ~clk_sys;
   fsr_host u_dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .flash_pins(pins),
      .dq_in(dq));
   fsr_flash_model u_flash (.pins(pins), .locked(locked),
      .vpen_low(vpen_low), .buf_free(buf_free), .dq(dq));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
      if (n >= 100) begin
         err_total++;
         final_report();
      end
   endtask
   task automatic op(input logic [3:0] c, input logic [7:0] cm,
      input logic [23:0] a, input logic [15:0] d);
      int n;
      bus(1'b1, 5'h04, {8'h00, a});
      bus(1'b1, 5'h08, {16'h0000, d});
      bus(1'b1, 5'h00, {1'b1, 19'h0, cm, c});
      n = 0;
      rv = 32'h0;
      while (rv[fsr_pkg::IRQ_DONE] !== 1'b1 && n < 200) begin
         bus(1'b0, fsr_pkg::REG_IRQ_STAT, 32'h0);
         n++;
      end
      if (n >= 200) begin
         err_total++;
         final_report();
      end
      bus(1'b0, 5'h08, 32'h0);
   endtask
   task automatic cmd(input logic [15:0] d);
      op(fsr_pkg::OP_WRITE_CMD, d[7:0], seed[23:0], d);
   endtask
   task automatic rdstat(input logic [3:0] c, input logic [7:0] e);
      op(c, 8'h00, 24'h0, 16'h0);
      bus(1'b0, {1'b0, fsr_pkg::REG_STAT}, 32'h0);
      chk({24'h0, rv[15:8]}, {24'h0, e});
   endtask
   task automatic poll(input logic [3:0] c);
      rdstat(c, 8'(exp_sr) & fsr_pkg::STATUS_POLL_MASK);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      for (int k = 0; k < 2; k++) begin
         seed = lfsr(seed);
         locked <= (k == 0);
         vpen_low <= (k == 1);
         cmd(16'h0040);
         op(fsr_pkg::OP_WRITE_CMD, fsr_pkg::CMD_WORD_PROGRAM, seed[23:0],
            seed[15:0]);
         exp_sr = (k == 0) ? 8'h92 : 8'h98;
         poll(fsr_pkg::OP_POLL_STATUS);
         poll(fsr_pkg::OP_CHECK_LOCK);
         cmd(16'h0050);
         exp_sr = 8'h80;
         poll(fsr_pkg::OP_POLL_STATUS);
         $display("program error case %0d done", k);
      end
      locked <= 1'b1;
      cmd(16'h0090);
      op(fsr_pkg::OP_READ, 8'h00, 24'h000002, 16'h0);
      chk(rv, 32'h00000001);
      locked <= 1'b0;
      cmd(16'h00B0);
      exp_sr = 8'h84;
      poll(fsr_pkg::OP_POLL_STATUS);
      cmd(16'h00D0);
      exp_sr = 8'h80;
      poll(fsr_pkg::OP_POLL_STATUS);
      for (int b = 0; b < 2; b++) begin
         buf_free <= b[0];
         cmd(16'h00E8);
         rdstat(fsr_pkg::OP_POLL_BUFFER, {b[0], 7'h00});
      end
      cmd(16'h0098);
      op(fsr_pkg::OP_READ, 8'h00, 24'h000010, 16'h0);
      chk(rv, 32'h00000051);
      $display("status tests done");
      cmd(16'h0070);
      bus(1'b1, fsr_pkg::REG_IRQ_MASK, 32'h1 << fsr_pkg::IRQ_DONE);
      bus(1'b1, 5'h00, 32'h80000000 | {28'h0, fsr_pkg::OP_POLL_STATUS});
      for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, fsr_pkg::REG_IRQ_STAT, 32'h0);
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, 5'h18, 32'h0);
      chk(rv, 32'h0);
      $display("interrupt tests done");
      final_report();
   end
endmodule
`default_nettype wire
